// ==== hw/balloon_command_relay.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - command code is three bits, zero to seven
// - board drives four status lines to modem
// - resend latest code until it changes
// - units accept frames only with matching id
// - cutdown code 001 enables heater current
// - vent acts on 011; cutdown ignores it
// - terminate indicator turns on, stays on
// - status indicator toggles about every second
// - heartbeat indicator blinks with heartbeat tone
// - heater pulses each second while terminate persists
// - heater drive is a PWM data line
// - idle code stops heater firing
module balloon_command_relay
  import relay_pkg::*;
(
  input wire logic clk_sys_i,                    // 25 MHz system clock
  input wire logic rst_n_i,                      // sync reset, active low
  input wire logic cmd_bit0_in_i,                // modem command bit 0 (pin)
  input wire logic cmd_bit1_in_i,                // modem command bit 1 (pin)
  input wire logic cmd_bit2_in_i,                // modem command bit 2 (pin)
  input wire logic [3:0] status_val_i,           // status word to send to modem
  input wire logic [15:0] net_id_i,              // own network identifier
  input wire logic [7:0] pwm_duty_i,             // heater duty, 0..255
  input wire radio_frame_t rx_frame_i,           // received radio frame
  input wire logic rx_valid_i,                   // received frame strobe
  output logic [3:0] status_out_o,               // status lines to modem
  output radio_frame_t tx_frame_o,               // frame to broadcast
  output logic tx_valid_o,                       // broadcast strobe
  output logic heartbeat_led_o,                  // heartbeat indicator
  output logic beat_tone_o,                      // heartbeat tone gate
  output logic status_led_o,                     // cutdown status indicator
  output logic terminate_latched_led_o,          // terminate seen indicator
  output logic heater_pwm_o,                     // heater switched-ground drive
  output logic vent_active_o,                    // vent actuator drive
  output logic [2:0] latest_cmd_o                // current modem code
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_r, sync1_nxt;   // first stage, read by sync2 only
  logic [2:0] sync2_r, sync2_nxt;   // second stage
  logic [2:0] prev_r, prev_nxt;     // second stage one cycle ago
  logic [3:0] stat_r, stat_nxt;     // registered status lines

  // modem bits are asynchronous levels, so two flops each
  always_comb begin
    sync1_nxt = {cmd_bit2_in_i, cmd_bit1_in_i, cmd_bit0_in_i};
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    stat_nxt = status_val_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync1_r <= CMD_IDLE;
      sync2_r <= CMD_IDLE;
      prev_r <= CMD_IDLE;
      stat_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ------------------------------------------------------------
  // slow enables
  // ------------------------------------------------------------
  logic sec_tick;     // one-second pulse
  logic resend_tick;  // retransmit pulse

  pulse_timer #(.PERIOD(TICK_CYCLES)) u_sec (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(1'b1),
    .tick_o(sec_tick)
  );

  pulse_timer #(.PERIOD(RESEND_CYCLES)) u_resend (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(1'b1),
    .tick_o(resend_tick)
  );

  // ------------------------------------------------------------
  // coordinator: resend latest code
  // ------------------------------------------------------------
  logic [2:0] code_r, code_nxt;     // latest modem code
  radio_frame_t tx_r, tx_nxt;       // outgoing frame
  logic txv_r, txv_nxt;             // outgoing strobe

  // the three bits are synchronised one by one, so skew between the modem
  // lines can show a false code for a cycle (000 to 011 may pass 001);
  // a code is taken only once it reads the same on two edges in a row
  // a new code goes out at once; otherwise it repeats on each resend tick
  always_comb begin
    code_nxt = code_r;
    if (sync2_r == prev_r) begin
      code_nxt = sync2_r;
    end
    tx_nxt = tx_r;
    txv_nxt = 1'b0;
    if (code_nxt != code_r || resend_tick) begin
      tx_nxt.net_id = net_id_i;
      tx_nxt.code = code_nxt;
      txv_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      code_r <= CMD_IDLE;
      tx_r <= '{net_id: NET_ID_RST, code: CMD_IDLE};
      txv_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      tx_r <= tx_nxt;
      txv_r <= txv_nxt;
    end
  end

  // ------------------------------------------------------------
  // remote units: filter by network id
  // ------------------------------------------------------------
  logic [2:0] unit_cmd_r, unit_cmd_nxt;  // last accepted code
  logic terminate_latched_led_r, terminate_latched_led_nxt;              // terminate ever seen
  logic vent_r, vent_nxt;                // vent running
  logic stled_r, stled_nxt;              // status indicator

  always_comb begin
    unit_cmd_nxt = unit_cmd_r;
    if (rx_valid_i && rx_frame_i.net_id == net_id_i) begin
      unit_cmd_nxt = rx_frame_i.code;
    end
    // sticky: only reset clears it
    terminate_latched_led_nxt = terminate_latched_led_r || (unit_cmd_r == CMD_TERMINATE);
    // vent follows 011; 001 and idle leave it off
    vent_nxt = (unit_cmd_r == CMD_VENT);
    stled_nxt = stled_r ^ sec_tick;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      unit_cmd_r <= CMD_IDLE;
      terminate_latched_led_r <= 1'b0;
      vent_r <= 1'b0;
      stled_r <= 1'b0;
    end else begin
      unit_cmd_r <= unit_cmd_nxt;
      terminate_latched_led_r <= terminate_latched_led_nxt;
      vent_r <= vent_nxt;
      stled_r <= stled_nxt;
    end
  end

  // ------------------------------------------------------------
  // heater firing: one burst per second, PWM inside it
  // ------------------------------------------------------------
  logic firing;                     // terminate active
  logic fire_d_r, fire_d_nxt;       // firing one cycle ago
  logic [CNT_W-1:0] burn_r, burn_nxt;  // remaining burst cycles
  logic [7:0] pwm_r, pwm_nxt;       // PWM phase
  logic heat_r, heat_nxt;           // heater drive

  assign firing = (unit_cmd_r == CMD_TERMINATE);

  // the first burst starts on the rise of firing so a unit powered up into
  // a standing terminate fires immediately; later bursts wait for a second
  // tick, otherwise the heater would burn without pause
  always_comb begin
    burn_nxt = burn_r;
    fire_d_nxt = firing;
    if (!firing) begin
      burn_nxt = '0;
    end else if (burn_r == '0 && (sec_tick || !fire_d_r)) begin
      burn_nxt = CNT_W'(HEAT_CYCLES);
    end else if (burn_r != '0) begin
      burn_nxt = burn_r - CNT_W'(1);
    end
    pwm_nxt = pwm_r + 8'h01;
    heat_nxt = firing && (burn_r != '0) && (pwm_r < pwm_duty_i);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      burn_r <= '0;
      fire_d_r <= 1'b0;
      pwm_r <= '0;
      heat_r <= 1'b0;
    end else begin
      burn_r <= burn_nxt;
      fire_d_r <= fire_d_nxt;
      pwm_r <= pwm_nxt;
      heat_r <= heat_nxt;
    end
  end

  // ------------------------------------------------------------
  // heartbeat: indicator and tone share one timer
  // ------------------------------------------------------------
  logic [CNT_W-1:0] beat_r, beat_nxt;   // flash remaining
  logic beat_led_r, beat_led_nxt;

  // tone and led come from one flop so they can never drift apart
  always_comb begin
    if (sec_tick) begin
      beat_nxt = CNT_W'(BEAT_CYCLES);
    end else if (beat_r != '0) begin
      beat_nxt = beat_r - CNT_W'(1);
    end else begin
      beat_nxt = '0;
    end
    beat_led_nxt = (beat_nxt != '0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      beat_r <= '0;
      beat_led_r <= 1'b0;
    end else begin
      beat_r <= beat_nxt;
      beat_led_r <= beat_led_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign status_out_o = stat_r;
  assign tx_frame_o = tx_r;
  assign tx_valid_o = txv_r;
  assign heartbeat_led_o = beat_led_r;
  assign beat_tone_o = beat_led_r;
  assign status_led_o = stled_r;
  assign terminate_latched_led_o = terminate_latched_led_r;
  assign heater_pwm_o = heat_r;
  assign vent_active_o = vent_r;
  assign latest_cmd_o = code_r;
endmodule

// ==== hw/relay_pkg.sv ====
package relay_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;       // system clock rate
  localparam int unsigned TICK_MS = 1000;            // slow tick period, ms
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HEAT_MS = 500;             // heater on-time per pulse, ms
  localparam int unsigned HEAT_CYCLES = CLK_HZ / 1000 * HEAT_MS;
  localparam int unsigned BEAT_MS = 100;             // heartbeat flash length, ms
  localparam int unsigned BEAT_CYCLES = CLK_HZ / 1000 * BEAT_MS;
  localparam int unsigned RESEND_MS = 100;           // retransmit spacing, ms
  localparam int unsigned RESEND_CYCLES = CLK_HZ / 1000 * RESEND_MS;
  localparam int unsigned CNT_W = 25;                // wide enough for TICK_CYCLES

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_IDLE = 3'h0;            // no unit acts
  localparam logic [2:0] CMD_TERMINATE = 3'h1;       // cutdown fires heater
  localparam logic [2:0] CMD_VENT = 3'h3;            // vent unit opens
  localparam logic [7:0] PWM_FULL = 8'hff;           // default heater duty
  localparam logic [15:0] NET_ID_RST = 16'h0000;     // network id reset value

  // one radio frame: network identifier and command code
  typedef struct packed {
    logic [15:0] net_id;
    logic [2:0] code;
  } radio_frame_t;
endpackage

// ==== hw/pulse_timer.sv ====
`timescale 1ns/1ns
// periodic enable: one-cycle pulse every PERIOD cycles
module pulse_timer
  import relay_pkg::*;
#(
  parameter int unsigned PERIOD = 2
) (
  input wire logic clk_sys_i,   // system clock
  input wire logic rst_n_i,     // sync reset, active low
  input wire logic run_i,       // counts while high, restarts when low
  output logic tick_o           // one-cycle pulse at period end
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  logic [CNT_W-1:0] cnt_r;   // current count
  logic [CNT_W-1:0] cnt_nxt; // next count

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_comb begin
    if (!run_i || cnt_r == LAST) begin
      cnt_nxt = '0;            // wrap or hold at zero
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_o = run_i && (cnt_r == LAST);
endmodule

// ==== verification/relay_chk.sv ====
`timescale 1ns/1ns
module relay_chk
  import relay_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic cmd_bit0_in_i, // pin 0
  input wire logic cmd_bit1_in_i, // pin 1
  input wire logic cmd_bit2_in_i, // pin 2
  input wire logic [3:0] status_val_i, // status word
  input wire logic [15:0] net_id_i, // own id
  input wire logic [7:0] pwm_duty_i, // duty
  input wire radio_frame_t rx_frame_i, // rx frame
  input wire logic rx_valid_i, // rx strobe
  input wire logic [3:0] status_out_o, // status lines
  input wire radio_frame_t tx_frame_o, // tx frame
  input wire logic tx_valid_o, // tx strobe
  input wire logic heartbeat_led_o, // beat led
  input wire logic beat_tone_o, // beat tone
  input wire logic terminate_latched_led_o, // sticky led
  input wire logic heater_pwm_o, // heater
  input wire logic vent_active_o, // vent
  input wire logic [2:0] latest_cmd_o // code
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [2:0] pins = {cmd_bit2_in_i, cmd_bit1_in_i, cmd_bit0_in_i}; // bit0 lsb
  wire logic acc = rx_valid_i && (rx_frame_i.net_id == net_id_i); // frame for us
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_status; 1 |=> status_out_o == $past(status_val_i); endproperty
  a_status: assert property (p_status) else $error("status lines wrong");
  property p_cmd;
    (pins == $past(pins) && pins == $past(pins, 2) && pins == $past(pins, 3)
     && pins == $past(pins, 4) && $past(rst_n_i, 4)) |-> latest_cmd_o == pins;
  endproperty
  a_cmd: assert property (p_cmd) else $error("code not taken");
  property p_tx;
    $changed(latest_cmd_o) |-> ##[0:1] (tx_valid_o && tx_frame_o.code == latest_cmd_o);
  endproperty
  a_tx: assert property (p_tx) else $error("no resend");
  property p_tx_pulse; tx_valid_o |=> !tx_valid_o; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("long strobe");
  property p_vent; acc && rx_frame_i.code == CMD_VENT |-> ##[1:3] vent_active_o; endproperty
  a_vent: assert property (p_vent) else $error("vent idle");
  property p_latch; terminate_latched_led_o |=> terminate_latched_led_o; endproperty
  a_latch: assert property (p_latch) else $error("led dropped");
  property p_idle;
    acc && rx_frame_i.code == CMD_IDLE |-> ##3 (!heater_pwm_o && !vent_active_o) [*8];
  endproperty
  a_idle: assert property (p_idle) else $error("idle acts");
  property p_heat;
    acc && rx_frame_i.code == CMD_TERMINATE && pwm_duty_i == PWM_FULL |-> ##[1:4] heater_pwm_o;
  endproperty
  a_heat: assert property (p_heat) else $error("heater cold");
  property p_beat; heartbeat_led_o == beat_tone_o; endproperty
  a_beat: assert property (p_beat) else $error("beat apart");
endmodule
bind balloon_command_relay relay_chk chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .cmd_bit0_in_i(cmd_bit0_in_i), .cmd_bit1_in_i(cmd_bit1_in_i), .cmd_bit2_in_i(cmd_bit2_in_i),
  .status_val_i(status_val_i), .net_id_i(net_id_i), .pwm_duty_i(pwm_duty_i),
  .rx_frame_i(rx_frame_i), .rx_valid_i(rx_valid_i), .status_out_o(status_out_o),
  .tx_frame_o(tx_frame_o), .tx_valid_o(tx_valid_o), .heartbeat_led_o(heartbeat_led_o),
  .beat_tone_o(beat_tone_o), .terminate_latched_led_o(terminate_latched_led_o),
  .heater_pwm_o(heater_pwm_o), .vent_active_o(vent_active_o), .latest_cmd_o(latest_cmd_o));

// ==== verification/modem_model.sv ====
`timescale 1ns/1ns
// modem side: puts the code on three separate lines, one edge late
module modem_model (
  input wire logic clk_sys_i, // clock
  input wire logic [2:0] code_i, // code from ground
  output logic [2:0] cmd_pins_o // bit0 to bit2 lines
);
  initial cmd_pins_o = 3'h0; // idle at power-up
  always @(posedge clk_sys_i) begin
    cmd_pins_o <= code_i;
  end
endmodule

// ==== verification/balloon_command_relay_test.sv ====
`timescale 1ns/1ns
module balloon_command_relay_test;
  import relay_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, rx_valid_i = 1'b0;
  logic [2:0] code = 3'h0, pins, last = 3'h0;
  logic [3:0] status_val_i = 4'h0, status_out_o;
  logic [15:0] net_id_i = 16'h0000;
  logic [7:0] pwm_duty_i = PWM_FULL;
  radio_frame_t rx_frame_i = '0, tx_frame_o;
  logic tx_valid_o, hb, tone, sled, tled, heat, vent;
  logic [2:0] latest_cmd_o;
  logic [2:0] expq[$]; // codes expected on broadcast
  int error_cnt = 0, checked = 0, r, h;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  modem_model modem (.clk_sys_i(clk_sys_i), .code_i(code), .cmd_pins_o(pins));
  balloon_command_relay dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cmd_bit0_in_i(pins[0]), .cmd_bit1_in_i(pins[1]), .cmd_bit2_in_i(pins[2]),
    .status_val_i(status_val_i), .net_id_i(net_id_i), .pwm_duty_i(pwm_duty_i),
    .rx_frame_i(rx_frame_i), .rx_valid_i(rx_valid_i), .status_out_o(status_out_o),
    .tx_frame_o(tx_frame_o), .tx_valid_o(tx_valid_o), .heartbeat_led_o(hb),
    .beat_tone_o(tone), .status_led_o(sled), .terminate_latched_led_o(tled),
    .heater_pwm_o(heat), .vent_active_o(vent), .latest_cmd_o(latest_cmd_o));
  // compare one value, report at once on mismatch
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one frame strobe, then let the units settle
  task automatic send(input logic [15:0] id, input logic [2:0] c);
    @(posedge clk_sys_i);
    rx_frame_i <= '{net_id: id, code: c};
    rx_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // broadcast watcher takes the oldest note for each strobe
  always @(negedge clk_sys_i) begin
    if (tx_valid_o === 1'b1) begin
      if (expq.size() == 0) cmp(16'(tx_frame_o.code), 16'hffff);
      else cmp(16'(tx_frame_o.code), 16'(expq.pop_front()));
    end
  end
  initial begin
    #(40 * 5000);
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'hb628));
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    net_id_i <= 16'($urandom());
    r = $urandom() % 8;
    // every code crosses the modem lines; each change of code is rebroadcast
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      code <= 3'(i ^ r);
      if (3'(i ^ r) != last) expq.push_back(3'(i ^ r));
      last = 3'(i ^ r);
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      cmp(16'(latest_cmd_o), 16'(i ^ r));
    end
    cmp(16'(expq.size()), 16'h0000);
    $display("test commands done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      status_val_i <= 4'($urandom());
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      cmp(16'(status_out_o), 16'(status_val_i));
    end
    $display("test status done");
    send(net_id_i ^ 16'h0001, CMD_VENT);
    cmp(16'(vent), 16'h0000);
    send(net_id_i, CMD_VENT);
    cmp(16'({vent, tled, heat}), 16'h0004);
    send(net_id_i, CMD_TERMINATE);
    h = heat;
    @(negedge clk_sys_i);
    cmp(16'({vent, tled, 1'(h | heat)}), 16'h0003);
    send(net_id_i ^ 16'h8000, CMD_IDLE);
    cmp(16'(tled), 16'h0001);
    send(net_id_i, CMD_IDLE);
    cmp(16'({vent, tled, heat}), 16'h0002);
    // the run is far shorter than one second tick, so indicators still rest
    cmp(16'({hb, tone, sled}), 16'h0000);
    $display("test units done");
    close_out();
  end
endmodule
